// file: ddr_mode_controller.sv
// memory controller end: AXI4-Lite registers, mode commands, refresh
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
module ddr_mode_controller (
  input wire logic ref_clk,
  input wire logic rst_n,
  ddr_cmd_if.ctl link,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  logic [7:0] aw_addr;
  logic aw_have;
  logic w_have;
  logic [31:0] w_data;
  logic [31:0] ctrl;
  logic [3:0] mr1_cfg;
  logic [2:0] mr2_cfg;
  logic [2:0] mr3_cfg;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic rd_done;
  logic [ddr_mode_pkg::CMD_W-1:0] pending;
  logic [7:0] ref_cnt;
  logic ref_due;
  logic [2:0] gap;
  logic wr_go;
  logic issue_ref;
  logic [ddr_mode_pkg::CMD_W-1:0] issue_bit;
  logic [7:0] refi;

  assign wr_go = aw_have && w_have && !s_bvalid;

  // address and data may be taken in either order
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      else if (wr_go)
        aw_have <= 1'b0;
      if (s_wvalid && s_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_wdata;
        s_wready <= 1'b0;
      end
      else if (wr_go)
        w_have <= 1'b0;
      if (s_bvalid && s_bready)
      begin
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // write response; unmapped offsets answer SLVERR
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= ddr_mode_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= (aw_addr > ddr_mode_pkg::OFS_STATUS || aw_addr[1:0] != 2'h0)
                 ? ddr_mode_pkg::RESP_SLVERR : ddr_mode_pkg::RESP_OKAY;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  // software registers; byte strobes are ignored, whole words only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= ddr_mode_pkg::CTRL_RESET;
      mr1_cfg <= 4'h0;
      mr2_cfg <= 3'h0;
      mr3_cfg <= 3'h0;
      wr_word <= 32'h00000000;
    end
    else if (wr_go)
    begin
      case (aw_addr)
        ddr_mode_pkg::OFS_CTRL: ctrl <= {29'h0, w_data[2:0]};
        ddr_mode_pkg::OFS_MR1: mr1_cfg <= w_data[3:0];
        ddr_mode_pkg::OFS_MR2: mr2_cfg <= w_data[2:0];
        ddr_mode_pkg::OFS_MR3: mr3_cfg <= w_data[2:0];
        ddr_mode_pkg::OFS_WDATA: wr_word <= w_data;
        default: ;
      endcase
    end
  end

  // read channel; one cycle from address to data
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
      s_rdata <= 32'h00000000;
      s_rresp <= ddr_mode_pkg::RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_arready <= 1'b0;
      s_rresp <= ddr_mode_pkg::RESP_OKAY;
      case (s_araddr)
        ddr_mode_pkg::OFS_CTRL: s_rdata <= ctrl;
        ddr_mode_pkg::OFS_MR1: s_rdata <= {28'h0, mr1_cfg};
        ddr_mode_pkg::OFS_MR2: s_rdata <= {29'h0, mr2_cfg};
        ddr_mode_pkg::OFS_MR3: s_rdata <= {29'h0, mr3_cfg};
        ddr_mode_pkg::OFS_WDATA: s_rdata <= wr_word;
        ddr_mode_pkg::OFS_RDATA: s_rdata <= rd_word;
        ddr_mode_pkg::OFS_STATUS: s_rdata <= {26'h0, rd_done, pending};
        default:
        begin
          s_rdata <= 32'h00000000;
          s_rresp <= ddr_mode_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // refresh interval halves in the extended range
  assign refi = ctrl[ddr_mode_pkg::CTRL_EXT_BIT]
              ? 8'(ddr_mode_pkg::REFI_EXT_CYC)
              : 8'(ddr_mode_pkg::REFI_NORMAL_CYC);
  assign issue_ref = ref_due && gap == 3'h0;
  assign issue_bit = (issue_ref || gap != 3'h0) ? '0
                   : pending & (~pending + 5'h1);

  // refresh timer; a new due event wins over its own clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_cnt <= 8'h00;
      ref_due <= 1'b0;
    end
    else if (!ctrl[ddr_mode_pkg::CTRL_REF_EN_BIT])
    begin
      ref_cnt <= 8'h00;
      ref_due <= 1'b0;
    end
    else if (ref_cnt + 8'h01 >= refi)
    begin
      ref_cnt <= 8'h00;
      ref_due <= 1'b1;
    end
    else
    begin
      ref_cnt <= ref_cnt + 8'h01;
      if (issue_ref)
        ref_due <= 1'b0;
    end
  end

  // pending orders: new request bits win over the issue clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pending <= '0;
    else if (wr_go && aw_addr == ddr_mode_pkg::OFS_CMD)
      pending <= (pending & ~issue_bit) | w_data[ddr_mode_pkg::CMD_W-1:0];
    else
      pending <= pending & ~issue_bit;
  end

  // read result; arrival wins over a clear written to status
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_word <= 32'h00000000;
      rd_done <= 1'b0;
    end
    else if (link.rvalid)
    begin
      rd_word <= link.rdata;
      rd_done <= 1'b1;
    end
    else if (wr_go && aw_addr == ddr_mode_pkg::OFS_STATUS &&
             w_data[ddr_mode_pkg::STAT_DONE_BIT])
      rd_done <= 1'b0;
  end

  // command issue, spaced by the mode command gap
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
      link.ba <= 3'h0;
      link.addr <= 14'h0000;
      link.wdata <= 32'h00000000;
      link.odt <= 1'b0;
      gap <= 3'h0;
    end
    else
    begin
      link.odt <= ctrl[ddr_mode_pkg::CTRL_ODT_BIT];
      link.wdata <= wr_word;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
      link.ba <= 3'h0;
      link.addr <= 14'h0000;
      if (gap != 3'h0)
        gap <= gap - 3'h1;
      if (issue_ref || issue_bit != '0)
        gap <= 3'(ddr_mode_pkg::MRD_CYC - 1);
      if (issue_ref)
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h1;
      case (issue_bit)
        5'h01:
        begin
          {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h0;
          link.ba <= ddr_mode_pkg::BANK_MR1;
          link.addr[ddr_mode_pkg::MR1_NOM_B0] <= mr1_cfg[0];
          link.addr[ddr_mode_pkg::MR1_NOM_B1] <= mr1_cfg[1];
          link.addr[ddr_mode_pkg::MR1_NOM_B2] <= mr1_cfg[2];
          link.addr[ddr_mode_pkg::MR1_WLEVEL_BIT] <= mr1_cfg[3];
        end
        5'h02:
        begin
          {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h0;
          link.ba <= ddr_mode_pkg::BANK_MR2;
          // zero in the field turns write termination off
          link.addr[ddr_mode_pkg::MR2_RTT_WR_LSB +: 2] <= mr2_cfg[1:0];
          // extended range: automatic or manual extended self-refresh
          if (ctrl[ddr_mode_pkg::CTRL_EXT_BIT])
          begin
            link.addr[ddr_mode_pkg::MR2_AUTO_BIT] <=
              mr2_cfg[ddr_mode_pkg::MR2_CFG_AUTO_BIT];
            link.addr[ddr_mode_pkg::MR2_EXT_BIT] <=
              !mr2_cfg[ddr_mode_pkg::MR2_CFG_AUTO_BIT];
          end
        end
        5'h04:
        begin
          {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h0;
          link.ba <= ddr_mode_pkg::BANK_MR3;
          // only A2:A0 are ever driven; reserved bits stay zero
          link.addr[2:0] <= mr3_cfg;
        end
        5'h08:
        begin
          {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h5;
          link.addr <= wr_word[13:0];
        end
        5'h10:
        begin
          {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h4;
          link.addr <= wr_word[13:0];
        end
        default: ;
      endcase
    end
  end
endmodule : ddr_mode_controller

// file: ddr_mode_pkg.sv
// shared constants, types and decode helpers for the mode-register link
package ddr_mode_pkg;
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int DATA_W = 32;

  // bank codes that select a mode register during a mode register set
  localparam logic [2:0] BANK_MR1 = 3'h1;
  localparam logic [2:0] BANK_MR2 = 3'h2;
  localparam logic [2:0] BANK_MR3 = 3'h3;

  // field positions on the address pins
  localparam int MR1_NOM_B0 = 2;
  localparam int MR1_NOM_B1 = 6;
  localparam int MR1_NOM_B2 = 9;
  localparam int MR1_WLEVEL_BIT = 7;
  localparam int MR2_AUTO_BIT = 6;
  localparam int MR2_EXT_BIT = 7;
  localparam int MR2_RTT_WR_LSB = 9;
  localparam int MR3_LOC_LSB = 0;
  localparam int MR3_RDO_BIT = 2;
  localparam int MR3_RSVD_LSB = 3;

  // predefined readout pattern for read training, location 0
  localparam logic [31:0] TRAIN_WORD = 32'h55555555;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int REFI_NORMAL_NS = 7800;
  localparam int REFI_EXT_NS = 3900;
  localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS / CLK_PERIOD_NS;
  localparam int REFI_EXT_CYC = REFI_EXT_NS / CLK_PERIOD_NS;
  localparam int MRD_CYC = 4;
  localparam int RD_LAT_CYC = 5;
  localparam int WR_ODT_CYC = 6;

  // controller register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MR1 = 8'h04;
  localparam logic [7:0] OFS_MR2 = 8'h08;
  localparam logic [7:0] OFS_MR3 = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_WDATA = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // controller register fields and reset values
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_REF_EN_BIT = 1;
  localparam int CTRL_ODT_BIT = 2;
  localparam int MR2_CFG_AUTO_BIT = 2;
  localparam int CMD_W = 5;
  localparam int STAT_DONE_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h00000002;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_REF, CMD_RD, CMD_WR}
    cmd_t;
  typedef enum logic [1:0] {TERM_OFF, TERM_NOM, TERM_WR} term_t;

  // decode the four command strobes into a command
  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_t c;
    c = CMD_NOP;
    if (!cs_n)
    begin
      case ({ras_n, cas_n, we_n})
        3'h0: c = CMD_MRS;
        3'h1: c = CMD_REF;
        3'h5: c = CMD_RD;
        3'h4: c = CMD_WR;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : decode_cmd
endpackage : ddr_mode_pkg

// file: ddr_cmd_if.sv
// command link between the memory controller and the memory device
interface ddr_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  logic odt;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;

  modport dev (
    input cs_n, ras_n, cas_n, we_n, ba, addr, odt, wdata,
    output rdata, rvalid
  );
  modport ctl (
    output cs_n, ras_n, cas_n, we_n, ba, addr, odt, wdata,
    input rdata, rvalid
  );
endinterface : ddr_cmd_if

// file: ddr_mode_device.sv
// memory device end: mode registers, dynamic termination, readout
module ddr_mode_device #(
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  ddr_cmd_if.dev link,
  output logic [1:0] term_sel,
  output logic [2:0] term_nom_code,
  output logic [1:0] term_wr_code,
  output logic rdo_active,
  output logic write_leveling,
  output logic self_refresh_auto,
  output logic self_refresh_ext,
  output logic reserved_error
);
  localparam int IDX_W = $clog2(DEPTH);
  localparam int LAT = ddr_mode_pkg::RD_LAT_CYC;

  // the array index comes from low column bits, so depth must be 2**n
  if (DEPTH < 2 || (1 << IDX_W) != DEPTH)
  begin : g_depth_check
    $error("DEPTH must be a power of two, at least 2");
  end

  ddr_mode_pkg::cmd_t cmd;
  logic [2:0] rtt_nom;
  logic wlevel;
  logic [1:0] rtt_wr;
  logic auto_sr;
  logic ext_sr;
  logic rdo_en;
  logic [1:0] rdo_loc;
  logic [3:0] wr_win;
  logic [ddr_mode_pkg::DATA_W-1:0] mem [DEPTH];
  logic [ddr_mode_pkg::DATA_W-1:0] rd_dat [LAT];
  logic [LAT-1:0] rd_vld;
  logic [ddr_mode_pkg::DATA_W-1:0] next_rd_word;
  ddr_mode_pkg::term_t next_term;
  logic is_mrs;

  // command strobes are sampled on every rising edge of the shared clock
  assign cmd = ddr_mode_pkg::decode_cmd(link.cs_n, link.ras_n,
                                         link.cas_n, link.we_n);
  assign is_mrs = (cmd == ddr_mode_pkg::CMD_MRS);

  // mode register 1: nominal termination and write leveling
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rtt_nom <= 3'h0;
      wlevel <= 1'b0;
    end
    else if (is_mrs && link.ba == ddr_mode_pkg::BANK_MR1)
    begin
      rtt_nom <= {link.addr[ddr_mode_pkg::MR1_NOM_B2],
                  link.addr[ddr_mode_pkg::MR1_NOM_B1],
                  link.addr[ddr_mode_pkg::MR1_NOM_B0]};
      wlevel <= link.addr[ddr_mode_pkg::MR1_WLEVEL_BIT];
    end
  end

  // mode register 2: write termination and self-refresh options
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rtt_wr <= 2'h0;
      auto_sr <= 1'b0;
      ext_sr <= 1'b0;
    end
    else if (is_mrs && link.ba == ddr_mode_pkg::BANK_MR2)
    begin
      // zero here turns the dynamic switch off entirely
      rtt_wr <= link.addr[ddr_mode_pkg::MR2_RTT_WR_LSB +: 2];
      auto_sr <= link.addr[ddr_mode_pkg::MR2_AUTO_BIT];
      ext_sr <= link.addr[ddr_mode_pkg::MR2_EXT_BIT];
    end
  end

  // mode register 3: readout enable and location
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdo_en <= 1'b0;
      rdo_loc <= 2'h0;
    end
    else if (is_mrs && link.ba == ddr_mode_pkg::BANK_MR3)
    begin
      rdo_en <= link.addr[ddr_mode_pkg::MR3_RDO_BIT];
      rdo_loc <= link.addr[ddr_mode_pkg::MR3_LOC_LSB +: 2];
    end
  end

  // sticky flag for reserved bits set in a mode register 3 write;
  // the part does not refuse such a write, it only reports it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reserved_error <= 1'b0;
    else if (is_mrs && link.ba[1:0] == 2'h3 &&
             (link.ba[2] ||
              link.addr[ddr_mode_pkg::ADDR_W-1:ddr_mode_pkg::MR3_RSVD_LSB]
              != 11'h000))
      reserved_error <= 1'b1;
  end

  // write window: the span in which write termination may apply
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_win <= 4'h0;
    else if (cmd == ddr_mode_pkg::CMD_WR)
      wr_win <= 4'(ddr_mode_pkg::WR_ODT_CYC);
    else if (wr_win != 4'h0)
      wr_win <= wr_win - 4'h1;
  end

  // termination choice, worked out without any mode command
  always_comb
  begin
    next_term = ddr_mode_pkg::TERM_OFF;
    if (link.odt)
    begin
      if (wr_win != 4'h0 && rtt_wr != 2'h0 && !wlevel)
        next_term = ddr_mode_pkg::TERM_WR;
      else if (rtt_nom != 3'h0)
        next_term = ddr_mode_pkg::TERM_NOM;
    end
  end

  // registered status towards the user side
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      term_sel <= 2'h0;
      term_nom_code <= 3'h0;
      term_wr_code <= 2'h0;
      rdo_active <= 1'b0;
      write_leveling <= 1'b0;
      self_refresh_auto <= 1'b0;
      self_refresh_ext <= 1'b0;
    end
    else
    begin
      term_sel <= next_term;
      term_nom_code <= rtt_nom;
      term_wr_code <= rtt_wr;
      rdo_active <= rdo_en;
      write_leveling <= wlevel;
      self_refresh_auto <= auto_sr;
      self_refresh_ext <= ext_sr;
    end
  end

  // data array; no reset, as a real array has none
  always_ff @(posedge ref_clk)
  begin
    if (cmd == ddr_mode_pkg::CMD_WR)
      mem[link.addr[IDX_W-1:0]] <= link.wdata;
  end

  // read source: pattern while readout is on, array otherwise
  always_comb
  begin
    next_rd_word = mem[link.addr[IDX_W-1:0]];
    if (rdo_en)
    begin
      // only location 0 holds a pattern; the others read zero
      if (rdo_loc == 2'h0)
        next_rd_word = ddr_mode_pkg::TRAIN_WORD;
      else
        next_rd_word = '0;
    end
    // with readout off the location bits play no part here
  end

  // read latency pipeline; back-to-back reads each keep their word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_vld <= '0;
      for (int i = 0; i < LAT; i++)
        rd_dat[i] <= '0;
    end
    else
    begin
      rd_vld <= {rd_vld[LAT-2:0], cmd == ddr_mode_pkg::CMD_RD};
      rd_dat[0] <= next_rd_word;
      for (int i = 1; i < LAT; i++)
        rd_dat[i] <= rd_dat[i-1];
    end
  end

  // read answer back to the controller, one cycle per word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.rvalid <= 1'b0;
      link.rdata <= '0;
    end
    else
    begin
      link.rvalid <= rd_vld[LAT-2];
      link.rdata <= rd_dat[LAT-2];
    end
  end
endmodule : ddr_mode_device

// file: ddr_link_monitor.sv
// wire-level assertions on the command link between the two ends
module ddr_link_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GLO = ddr_mode_pkg::REFI_EXT_CYC - 1;
  localparam int GHI = ddr_mode_pkg::REFI_NORMAL_CYC + ddr_mode_pkg::MRD_CYC;
  logic mrs;
  logic rd;
  logic rf;
  logic seen;
  logic [2:0] mr3;
  logic [8:0] gap;
  // command decode straight from the strobes
  assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
  assign rd = !cs_n && ras_n && !cas_n && we_n;
  assign rf = !cs_n && !ras_n && !cas_n && we_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // readout setting as last sent, so data is judged without the device
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mr3 <= 3'h0;
    else if (mrs && ba == 3'h3)
      mr3 <= addr[2:0];
  end
  // cycles since the last refresh; saturates so it never wraps
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gap <= 9'h0;
    else if (rf)
      gap <= 9'h1;
    else if (gap != 9'h1FF)
      gap <= gap + 9'h1;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      seen <= 1'b0;
    else if (rf)
      seen <= 1'b1;
  end
  sequence s_rd_cmd;
    rd;
  endsequence
  sequence s_beat;
    rvalid ##1 !rvalid;
  endsequence
  AST_MRS_BANK: assert property (mrs |-> ba inside {3'h1, 3'h2, 3'h3})
    else $error("mode command to an unknown bank");
  AST_MR3_RSVD: assert property (mrs && ba[1:0] == 2'h3 |->
    ba == 3'h3 && addr[13:3] == 11'h0)
    else $error("reserved bits set in readout mode command");
  AST_MR2_SR: assert property (mrs && ba == 3'h2 |-> !(addr[6] && addr[7]))
    else $error("self-refresh mode bits both set");
  AST_RD_LAT: assert property (s_rd_cmd |-> ##5 s_beat)
    else $error("read word late or not a single cycle");
  AST_RV_CAUSE: assert property ($rose(rvalid) |-> $past(rd, 5))
    else $error("read word without a read command");
  AST_RDO_DATA: assert property (rvalid && mr3[2] |-> rdata ==
    (mr3[1:0] == 2'h0 ? ddr_mode_pkg::TRAIN_WORD : 32'h0))
    else $error("readout word wrong");
  AST_REFI: assert property (rf && seen |-> gap >= GLO && gap <= GHI)
    else $error("refresh spacing out of range");
  AST_QUIET: assert property (!cs_n |=> cs_n [*3])
    else $error("commands closer than the mode spacing");
endmodule : ddr_link_monitor

// file: test_ddr_mr3_and_dynamic_odt_modes.sv
// bench: controller and device joined, plus a device fed a faulty command
module test_ddr_mr3_and_dynamic_odt_modes;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, resp, term_sel, term_wr_code;
  logic [31:0] s_rdata, rd_val;
  logic rdo_active, write_leveling, sr_auto, sr_ext, rdo_b, rsv_b, hit;
  logic rsv_a;
  logic [2:0] nom_code;
  int error_cnt = 0;
  int tests_run = 0;
  int g;
  ddr_cmd_if link();
  ddr_cmd_if flt();
  wire lref = !link.cs_n && !link.ras_n && !link.cas_n && link.we_n;
  ddr_mode_controller u_ddr_mode_controller (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link.ctl), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  ddr_mode_device u_ddr_mode_device (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link.dev), .term_sel(term_sel), .term_nom_code(nom_code),
    .term_wr_code(term_wr_code), .rdo_active(rdo_active),
    .write_leveling(write_leveling), .self_refresh_auto(sr_auto),
    .self_refresh_ext(sr_ext), .reserved_error(rsv_a));
  // second device, driven by the bench acting as a careless controller
  ddr_mode_device u_ddr_mode_device_2 (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(flt.dev), .term_sel(), .term_nom_code(), .term_wr_code(),
    .rdo_active(rdo_b), .write_leveling(), .self_refresh_auto(),
    .self_refresh_ext(), .reserved_error(rsv_b));
  ddr_link_monitor u_ddr_link_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
    .rdata(link.rdata), .rvalid(link.rvalid));
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, bready held until the answer
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end
    while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end
    while (s_rvalid !== 1'b1);
    rd_val = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  // request one link command, then poll status until it has gone out, or for a read until its word has come back
  task cmd(input int b);
    if (b == 3) wr(ddr_mode_pkg::OFS_STATUS, 32'h20);
    wr(ddr_mode_pkg::OFS_CMD, 32'h1 << b);
    do rd(ddr_mode_pkg::OFS_STATUS);
    while (b == 3 ? rd_val[5] !== 1'b1 : rd_val[4:0] !== 5'h0);
    repeat (6) @(posedge ref_clk);
  endtask : cmd
  // issue a write on the link and watch for write termination
  task wr_term;
    hit = 1'b0;
    wr(ddr_mode_pkg::OFS_CMD, 32'h10);
    repeat (20) @(posedge ref_clk) if (term_sel === 2'h2) hit = 1'b1;
  endtask : wr_term
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // a hang is cut short well past the thousand or so cycles the run needs
  initial
  begin
    #(40 * 30000);
    error_cnt++;
    stop_test;
  end
  initial
  begin
    flt.cs_n = 1'b1;
    flt.ras_n = 1'b1;
    flt.cas_n = 1'b1;
    flt.we_n = 1'b1;
    flt.ba = 3'h0;
    flt.addr = 14'h0;
    flt.odt = 1'b0;
    flt.wdata = 32'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ddr_mode_pkg::OFS_CTRL);
    chk(rd_val, ddr_mode_pkg::CTRL_RESET);
    rd(8'h20);
    chk(32'(resp), 32'(ddr_mode_pkg::RESP_SLVERR));
    // a write to an unmapped offset is answered with an error too
    wr(8'h20, 32'h1);
    chk(32'(resp), 32'(ddr_mode_pkg::RESP_SLVERR));
    $display("registers done");
    // readout on at location 0, then location 1
    wr(ddr_mode_pkg::OFS_MR3, 32'h4);
    cmd(2);
    chk(32'(rdo_active), 32'h1);
    wr(ddr_mode_pkg::OFS_WDATA, 32'h0);
    cmd(3);
    rd(ddr_mode_pkg::OFS_RDATA);
    chk(rd_val, ddr_mode_pkg::TRAIN_WORD);
    wr(ddr_mode_pkg::OFS_MR3, 32'h5);
    cmd(2);
    cmd(3);
    rd(ddr_mode_pkg::OFS_RDATA);
    chk(rd_val, 32'h0);
    // readout off with location bits set: the stored word comes back
    wr(ddr_mode_pkg::OFS_MR3, 32'h3);
    cmd(2);
    chk(32'(rdo_active), 32'h0);
    wr(ddr_mode_pkg::OFS_WDATA, 32'h3);
    cmd(4);
    cmd(3);
    rd(ddr_mode_pkg::OFS_RDATA);
    chk(rd_val, 32'h3);
    $display("readout done");
    // write termination switches in on a write, with no mode command
    wr(ddr_mode_pkg::OFS_MR1, 32'h1);
    cmd(0);
    wr(ddr_mode_pkg::OFS_MR2, 32'h2);
    cmd(1);
    chk(32'(term_wr_code), 32'h2);
    chk(32'(nom_code), 32'h1);
    wr(ddr_mode_pkg::OFS_CTRL, 32'h6);
    repeat (3) @(posedge ref_clk);
    chk(32'(term_sel), 32'h1);
    wr_term;
    chk(32'(hit), 32'h1);
    wr(ddr_mode_pkg::OFS_MR1, 32'h9);
    cmd(0);
    chk(32'(write_leveling), 32'h1);
    wr_term;
    chk(32'(hit), 32'h0);
    wr(ddr_mode_pkg::OFS_MR1, 32'h1);
    cmd(0);
    wr(ddr_mode_pkg::OFS_MR2, 32'h0);
    cmd(1);
    chk(32'(term_wr_code), 32'h0);
    $display("termination done");
    // extended temperature: both self-refresh modes, faster refresh
    wr(ddr_mode_pkg::OFS_CTRL, 32'h3);
    wr(ddr_mode_pkg::OFS_MR2, 32'h4);
    cmd(1);
    chk(32'({sr_auto, sr_ext}), 32'h2);
    wr(ddr_mode_pkg::OFS_MR2, 32'h0);
    cmd(1);
    chk(32'({sr_auto, sr_ext}), 32'h1);
    repeat (2)
    begin
      g = 0;
      do @(posedge ref_clk);
      while (lref !== 1'b1);
      do
      begin
        @(posedge ref_clk);
        g++;
      end
      while (lref !== 1'b1);
    end
    // idle link: refreshes come exactly one interval apart
    chk(32'(g), 32'(ddr_mode_pkg::REFI_EXT_CYC));
    $display("temperature done");
    // careless controller sets a reserved bit with readout on
    @(posedge ref_clk);
    flt.cs_n <= 1'b0;
    flt.ras_n <= 1'b0;
    flt.cas_n <= 1'b0;
    flt.we_n <= 1'b0;
    flt.ba <= 3'h3;
    flt.addr <= 14'h0024;
    @(posedge ref_clk);
    flt.cs_n <= 1'b1;
    flt.addr <= 14'h3FDB;
    repeat (3) @(posedge ref_clk);
    chk(32'(rsv_b), 32'h1);
    chk(32'(rdo_b), 32'h1);
    chk(32'(rsv_a), 32'h0);
    $display("fault done");
    stop_test;
  end
endmodule : test_ddr_mr3_and_dynamic_odt_modes
